// file: atc_defines.vh
// What this block does
// - overflow sets overflow flag unless baud source
// - trigger edge capture/reload sets external edge flag
// - receive baud select picks overflow source
// - transmit baud select picks overflow source
// - trigger pin enable gates capture or reload
// - run control gates counting, count held
// - timer mode counts every two clocks
// - counter mode counts count pin falling edges
// - capture/reload select, baud forces overflow reload
// - reload/capture byte pair, reset zero, RW
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH
// ************************************************************
// register indices; each byte address is four times its index
// ************************************************************
`define ATC_IDX_CTRL      8'hC8
`define ATC_IDX_RCAP_LO   8'hCA
`define ATC_IDX_RCAP_HI   8'hCB
`define ATC_IDX_CNT_LO    8'hCC
`define ATC_IDX_CNT_HI    8'hCD
`define ATC_ADDR_CTRL     {`ATC_IDX_CTRL, 2'b00}
`define ATC_ADDR_RCAP_LO  {`ATC_IDX_RCAP_LO, 2'b00}
`define ATC_ADDR_RCAP_HI  {`ATC_IDX_RCAP_HI, 2'b00}
`define ATC_ADDR_CNT_LO   {`ATC_IDX_CNT_LO, 2'b00}
`define ATC_ADDR_CNT_HI   {`ATC_IDX_CNT_HI, 2'b00}
// ************************************************************
// control field positions
// ************************************************************
`define ATC_BIT_OVF       7
`define ATC_BIT_EXF       6
`define ATC_BIT_RXSRC     5
`define ATC_BIT_TXSRC     4
`define ATC_BIT_TRGEN     3
`define ATC_BIT_RUN       2
`define ATC_BIT_CSRC      1
`define ATC_BIT_CAPSEL    0
// ************************************************************
// reset values and timing
// ************************************************************
`define ATC_RST_BYTE      8'h00
`define ATC_TICK_DIV      2
// ************************************************************
// bus responses
// ************************************************************
`define ATC_RESP_OKAY     2'h0
`define ATC_RESP_SLVERR   2'h2
`endif

// file: atc_timer.v
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "atc_defines.vh"
// ************************************************************
// aux timer: 16-bit timer/counter with capture and reload
// ************************************************************
module atc_timer
(
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ext_count_pin,
    input  wire        ext_trigger_pin,
    input  wire        other_timer_ovf,
    output reg         rx_baud_tick,
    output reg         tx_baud_tick
);
    // ************************************************************
    // state
    // ************************************************************
    reg [7:0]  ctrl_r;      // control register
    reg [15:0] rcap_r;      // reload / capture value
    reg [15:0] cnt_r;       // count
    reg [1:0]  cpin_sync_r; // count pin synchroniser
    reg [1:0]  tpin_sync_r; // trigger pin synchroniser
    reg        cpin_old_r;  // previous synced count pin
    reg        tpin_old_r;  // previous synced trigger pin
    reg        div_r;       // half rate divider
    reg        aw_hold_r;   // write address taken
    reg        w_hold_r;    // write data taken
    reg [9:0]  aw_addr_r;   // held write byte address
    reg [31:0] w_data_r;    // held write data
    reg        w_strb0_r;   // held lane 0 strobe

    // ************************************************************
    // combinational event logic
    // ************************************************************
    wire baud_mode = ctrl_r[`ATC_BIT_RXSRC] | ctrl_r[`ATC_BIT_TXSRC];
    // falling edges from the second synchroniser stage onward
    wire cpin_fall = cpin_old_r & ~cpin_sync_r[1];
    wire tpin_fall = tpin_old_r & ~tpin_sync_r[1];
    // half rate tick or count pin edge
    wire inc_ev = ctrl_r[`ATC_BIT_CSRC] ? cpin_fall : div_r;
    wire step = ctrl_r[`ATC_BIT_RUN] & inc_ev;
    wire ovf = step & (cnt_r == 16'hFFFF);
    // trigger acts only with enable and no baud source selected
    wire trg = tpin_fall & ctrl_r[`ATC_BIT_TRGEN] & ~baud_mode;
    wire do_cap = trg & ctrl_r[`ATC_BIT_CAPSEL];
    wire do_rld = ovf & (baud_mode | ~ctrl_r[`ATC_BIT_CAPSEL])
                | (trg & ~ctrl_r[`ATC_BIT_CAPSEL]);
    wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    wire wr_ok = wr_go & w_strb0_r;

    // ************************************************************
    // pin synchronisers and divider
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cpin_sync_r <= 2'h3;
            tpin_sync_r <= 2'h3;
            cpin_old_r  <= 1'b1;
            tpin_old_r  <= 1'b1;
            div_r       <= 1'b0;
        end
        else
        begin
            cpin_sync_r <= {cpin_sync_r[0], ext_count_pin};
            tpin_sync_r <= {tpin_sync_r[0], ext_trigger_pin};
            cpin_old_r  <= cpin_sync_r[1];
            tpin_old_r  <= tpin_sync_r[1];
            // divider free runs; timer mode steps every other clock
            div_r       <= ~div_r;
        end
    end

    // ************************************************************
    // counter, capture and flags; hardware set wins over clear
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `ATC_RST_BYTE;
            rcap_r <= {`ATC_RST_BYTE, `ATC_RST_BYTE};
            cnt_r  <= {`ATC_RST_BYTE, `ATC_RST_BYTE};
        end
        else
        begin
            // software writes first, hardware events below override
            if (wr_ok)
            begin
                case (aw_addr_r)
                    `ATC_ADDR_CTRL:    ctrl_r       <= w_data_r[7:0];
                    `ATC_ADDR_RCAP_LO: rcap_r[7:0]  <= w_data_r[7:0];
                    `ATC_ADDR_RCAP_HI: rcap_r[15:8] <= w_data_r[7:0];
                    `ATC_ADDR_CNT_LO:  cnt_r[7:0]   <= w_data_r[7:0];
                    `ATC_ADDR_CNT_HI:  cnt_r[15:8]  <= w_data_r[7:0];
                    default:           ;
                endcase
            end
            // count, reload beats increment
            if (do_rld)
                cnt_r <= rcap_r;
            else if (step)
                cnt_r <= cnt_r + 16'h0001;
            // capture copies the live count
            if (do_cap)
                rcap_r <= cnt_r;
            // overflow flag only outside baud mode
            if (ovf & ~baud_mode)
                ctrl_r[`ATC_BIT_OVF] <= 1'b1;
            // trigger capture or reload flag
            if (trg)
                ctrl_r[`ATC_BIT_EXF] <= 1'b1;
        end
    end

    // ************************************************************
    // baud tick outputs to serial port
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end
        else
        begin
            rx_baud_tick <= ctrl_r[`ATC_BIT_RXSRC] ? ovf : other_timer_ovf;
            tx_baud_tick <= ctrl_r[`ATC_BIT_TXSRC] ? ovf : other_timer_ovf;
        end
    end

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ATC_RESP_OKAY;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 10'h000;
            w_data_r      <= 32'h00000000;
            w_strb0_r     <= 1'b0;
        end
        else
        begin
            // take address and data in either order
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_hold_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_hold_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb0_r    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            // both held: respond; the register is written only if the lane 0 strobe was set
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                case (aw_addr_r)
                    `ATC_ADDR_CTRL, `ATC_ADDR_RCAP_LO, `ATC_ADDR_RCAP_HI,
                    `ATC_ADDR_CNT_LO, `ATC_ADDR_CNT_HI:
                        s_axi_bresp <= `ATC_RESP_OKAY;
                    default:
                        s_axi_bresp <= `ATC_RESP_SLVERR;
                endcase
            end
            // response accepted: reopen both channels
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ATC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `ATC_RESP_OKAY;
                // narrow data in low byte, upper bits zero
                case (s_axi_araddr)
                    `ATC_ADDR_CTRL:    s_axi_rdata <= {24'h000000, ctrl_r};
                    `ATC_ADDR_RCAP_LO: s_axi_rdata <= {24'h000000, rcap_r[7:0]};
                    `ATC_ADDR_RCAP_HI: s_axi_rdata <= {24'h000000, rcap_r[15:8]};
                    `ATC_ADDR_CNT_LO:  s_axi_rdata <= {24'h000000, cnt_r[7:0]};
                    `ATC_ADDR_CNT_HI:  s_axi_rdata <= {24'h000000, cnt_r[15:8]};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `ATC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // atc_timer
`default_nettype wire

// file: atc_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_defines.vh"
module atc_timer_chk
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [9:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        other_timer_ovf,
    input wire logic        rx_baud_tick,
    input wire logic        tx_baud_tick
);
    logic [9:0] adr_r;  // address of the write under way
    logic [7:0] dat_r;  // data of the write under way
    logic [1:0] sel_r;  // shadow of the baud source bits
    // snoop control writes so the baud selection is known
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sel_r <= 2'h0;
        else if (s_axi_bvalid && adr_r == `ATC_ADDR_CTRL)
            sel_r <= dat_r[5:4];
        if (s_axi_awvalid && s_axi_awready)
            adr_r <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            dat_r <= s_axi_wdata[7:0];
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_rx_other: assert property (!s_axi_bvalid && !sel_r[1] |=>
        rx_baud_tick == $past(other_timer_ovf)) else $error("rx tick wrong");
    a_tx_other: assert property (!s_axi_bvalid && !sel_r[0] |=>
        tx_baud_tick == $past(other_timer_ovf)) else $error("tx tick wrong");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write answer");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("bad read answer");
    a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read early");
    a_gap_err: assert property (s_axi_bvalid && adr_r == {8'hC9, 2'b00} |->
        s_axi_bresp == `ATC_RESP_SLVERR) else $error("no error response");
    a_ctrl_okay: assert property (s_axi_bvalid && adr_r == `ATC_ADDR_CTRL |->
        s_axi_bresp == `ATC_RESP_OKAY) else $error("control write refused");
    c_rx: cover property (rx_baud_tick);
    c_tx: cover property (tx_baud_tick);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == `ATC_RESP_SLVERR);
endmodule // atc_timer_chk
bind atc_timer atc_timer_chk chk_i (.*);
`default_nettype wire

// file: atc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// pins and other-timer pulse seen from outside the timer
module atc_pins
(
    input  wire logic sys_clk,
    output var  logic ext_count_pin,
    output var  logic ext_trigger_pin,
    output var  logic other_timer_ovf
);
    initial
    begin
        ext_count_pin = 1'b1;
        ext_trigger_pin = 1'b1;
        other_timer_ovf = 1'b0;
    end
    // w: 0 count pin fall, 1 trigger pin fall, 2 one-cycle overflow pulse
    task automatic pulse(input int w, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            if (w == 0) ext_count_pin <= 1'b0;
            if (w == 1) ext_trigger_pin <= 1'b0;
            if (w == 2) other_timer_ovf <= 1'b1;
            @(posedge sys_clk);
            other_timer_ovf <= 1'b0;
            repeat (2) @(posedge sys_clk);
            ext_count_pin <= 1'b1;
            ext_trigger_pin <= 1'b1;
            repeat (3) @(posedge sys_clk);
        end
    endtask
endmodule // atc_pins
`default_nettype wire

// file: atc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_defines.vh"
module atc_timer_tb;
    logic        sys_clk, rst_n, ext_count_pin, ext_trigger_pin, other_timer_ovf;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        rx_baud_tick, tx_baud_tick;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          n_fail = 0, checked = 0, n_rx = 0, n_tx = 0, rx0, tx0;
    atc_timer dut (.*);
    atc_pins pins (.*);
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // tally baud ticks seen at the serial port side
    always @(posedge sys_clk)
    begin
        if (rx_baud_tick === 1'b1) n_rx <= n_rx + 1;
        if (tx_baud_tick === 1'b1) n_tx <= n_tx + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        forever
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
    endtask
    task automatic rd(input logic [9:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        rd(a);
        chk(v, exp);
    endtask
    // stop first (a running step beats a count write), then count, reload, control
    task automatic cfg(input logic [15:0] c, input logic [15:0] r, input logic [7:0] t);
        wr(`ATC_ADDR_CTRL, 32'h0);
        wr(`ATC_ADDR_CNT_LO, {24'h0, c[7:0]});
        wr(`ATC_ADDR_CNT_HI, {24'h0, c[15:8]});
        wr(`ATC_ADDR_RCAP_LO, {24'h0, r[7:0]});
        wr(`ATC_ADDR_RCAP_HI, {24'h0, r[15:8]});
        wr(`ATC_ADDR_CTRL, {24'h0, t});
    endtask
    task automatic summarize;
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 8'hC8; a <= 8'hCD; a++)
            if (a != 8'hC9) rd_chk({8'(a), 2'b00}, 32'h0);
        wr(`ATC_ADDR_RCAP_LO, 32'h5A);
        rd_chk(`ATC_ADDR_RCAP_LO, 32'h5A);
        wr({8'hC9, 2'b00}, 32'hFF);
        chk(rs, `ATC_RESP_SLVERR);
        rd_chk({8'hC9, 2'b00}, 32'h0);
        chk(rs, `ATC_RESP_SLVERR);
        cfg(16'h0, 16'h0, 8'h04);
        repeat (40) @(posedge sys_clk);
        wr(`ATC_ADDR_CTRL, 32'h0);
        rd(`ATC_ADDR_CNT_LO);
        chk(v inside {20, 21, 22}, 32'h1);
        repeat (20) @(posedge sys_clk);
        rd_chk(`ATC_ADDR_CNT_LO, v);
        cfg(16'hFFFE, 16'h1234, 8'h04);
        repeat (10) @(posedge sys_clk);
        rd_chk(`ATC_ADDR_CTRL, 32'h84);
        rd_chk(`ATC_ADDR_CNT_HI, 32'h12);
        wr(`ATC_ADDR_CTRL, 32'h04);
        rd_chk(`ATC_ADDR_CTRL, 32'h04);
        {rx0, tx0} = {n_rx, n_tx};
        cfg(16'hFFFE, 16'h1234, 8'h35);
        repeat (10) @(posedge sys_clk);
        rd_chk(`ATC_ADDR_CTRL, 32'h35);
        rd_chk(`ATC_ADDR_CNT_HI, 32'h12);
        chk(n_rx - rx0, 32'h1);
        chk(n_tx - tx0, 32'h1);
        cfg(16'h0, 16'h0, 8'h06);
        pins.pulse(0, 5);
        wr(`ATC_ADDR_CTRL, 32'h0);
        rd_chk(`ATC_ADDR_CNT_LO, 32'h5);
        cfg(16'h7700, 16'h1234, 8'h05);
        pins.pulse(1, 1);
        rd_chk(`ATC_ADDR_CTRL, 32'h05);
        wr(`ATC_ADDR_CTRL, 32'h0D);
        pins.pulse(1, 1);
        rd_chk(`ATC_ADDR_CTRL, 32'h4D);
        rd_chk(`ATC_ADDR_RCAP_HI, 32'h77);
        wr(`ATC_ADDR_RCAP_HI, 32'h12);
        wr(`ATC_ADDR_CTRL, 32'h0C);
        pins.pulse(1, 1);
        rd_chk(`ATC_ADDR_CTRL, 32'h4C);
        rd_chk(`ATC_ADDR_CNT_HI, 32'h12);
        wr(`ATC_ADDR_CTRL, 32'h0);
        {rx0, tx0} = {n_rx, n_tx};
        pins.pulse(2, 1);
        chk(n_rx - rx0, 32'h1);
        chk(n_tx - tx0, 32'h1);
        summarize();
    end
endmodule // atc_timer_tb
`default_nettype wire
